// File: src/can_id_filter_defines.svh
`ifndef CAN_ID_FILTER_DEFINES_SVH
`define CAN_ID_FILTER_DEFINES_SVH
// ======================================================================
// Register offsets in the special function register space
`define TAG_ONE_ADDR 8'hbc
`define TAG_TWO_ADDR 8'hbd
`define TAG_THREE_ADDR 8'hbe
`define TAG_FOUR_ADDR 8'hbf
`define MASK_ONE_ADDR 8'hc4
`define MASK_TWO_ADDR 8'hc5
`define MASK_THREE_ADDR 8'hc6
`define MASK_FOUR_ADDR 8'hc7
// ======================================================================
// Field positions in register four (tag and mask)
`define RTR_BIT 2
`define RB1_BIT 1
`define RB0_BIT 0
`define IDE_BIT 0
// Standard layout: bits 2..0 of identifier sit in bits 7..5
`define STD_LOW_LSB 5
// Extended layout: bits 4..0 of identifier sit in bits 7..3
`define EXT_LOW_LSB 3
// Identifier width of the extended layout
`define EXT_ID_BITS 29
// Number of tag/mask registers
`define NUM_REGS 8
// Value returned by reads of unmapped addresses
`define RSVD_READ 8'h00
`endif

// File: src/can_id_filter_pkg.sv
package can_id_filter_pkg;
   typedef logic [7:0] byte_t;
   // Received frame header as seen by the acceptance filter
   typedef struct packed {
      logic ext;
      logic [28:0] ident;
      logic rtr;
      logic rb1;
      logic rb0;
   } rx_hdr_s;
   // Frame header that a transmitting channel sends
   typedef struct packed {
      logic ext;
      logic [28:0] ident;
      logic rtr;
      logic rb1;
      logic rb0;
   } tx_hdr_s;
endpackage : can_id_filter_pkg

// File: src/can_channel_id_filter_regs.sv
`timescale 1ns/1ns
`include "can_id_filter_defines.svh"

// Behaviour
// RL1 - Extended tag regs hold ID 28:21, 20:13, 12:5, and 4:0 in reg4 7:3.
// RL2 - Extended tag reg four: remote tag bit 2, rb1 bit 1, rb0 bit 0.
// RL3 - Standard mask: reg one holds mask 10:3, reg two bits 7:5 mask 2:0.
// RL4 - Extended mask reg one holds mask bits 28 down to 21.
// RL5 - Mask 0 forces bit match, 1 enables compare, incl. remote and IDE.
// RL6 - Mask applies only to reception; transmit header ignores mask.
// RL7 - Software writes no ones to reserved bits, treats reads undefined.
// RL8 - Registers not reset; software programs them before enabling channel.
// RL9 - Standard tag: reg one holds ID 10:3, reg two bits 7:5 hold ID 2:0.
// RL10 - Frame accepted when each compared bit equals tag or its mask is 0.
module can_channel_id_filter_regs (
   input wire logic mclk,
   input wire logic srst,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic ext_format,
   input wire logic rx_check,
   input wire can_id_filter_pkg::rx_hdr_s rx_hdr,
   output logic rx_accept,
   output can_id_filter_pkg::tx_hdr_s tx_hdr
);

   // ===================================================================
   // Register storage
   // Index 0..3 tag one..four, 4..7 mask one..four.
   // No reset: contents stay undefined until software writes them. [RL8]
   can_id_filter_pkg::byte_t regs_q [`NUM_REGS];
   can_id_filter_pkg::byte_t regs_d [`NUM_REGS];
   logic [2:0] idx;
   logic idx_ok;
   // One-hot write select keeps each register's enable a single gate
   logic [7:0] reg_sel;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   always_comb
   begin
      idx_ok = 1'b1;
      idx = 3'h0;
      reg_sel = 8'h00;
      case (sfr_addr)
         `TAG_ONE_ADDR:
         begin
            idx = 3'h0;
            reg_sel = 8'h01;
         end
         `TAG_TWO_ADDR:
         begin
            idx = 3'h1;
            reg_sel = 8'h02;
         end
         `TAG_THREE_ADDR:
         begin
            idx = 3'h2;
            reg_sel = 8'h04;
         end
         `TAG_FOUR_ADDR:
         begin
            idx = 3'h3;
            reg_sel = 8'h08;
         end
         `MASK_ONE_ADDR:
         begin
            idx = 3'h4;
            reg_sel = 8'h10;
         end
         `MASK_TWO_ADDR:
         begin
            idx = 3'h5;
            reg_sel = 8'h20;
         end
         `MASK_THREE_ADDR:
         begin
            idx = 3'h6;
            reg_sel = 8'h40;
         end
         `MASK_FOUR_ADDR:
         begin
            idx = 3'h7;
            reg_sel = 8'h80;
         end
         default:
         begin
            idx_ok = 1'b0;
         end
      endcase
   end

   assign sfr_hit = idx_ok;

   genvar g;
   generate
      for (g = 0; g < `NUM_REGS; g++)
      begin : g_reg
         always_comb
         begin
            regs_d[g] = regs_q[g];
            // Reserved bits are stored as written; software keeps them 0. [RL7]
            if (sfr_wr && reg_sel[g])
            begin
               regs_d[g] = sfr_wdata;
            end
         end
         always_ff @(posedge mclk)
         begin
            regs_q[g] <= regs_d[g];
         end
      end
   endgenerate

   // ===================================================================
   // Named views of the eight registers
   logic [7:0] ident_tag_reg_one;
   logic [7:0] ident_tag_reg_two;
   logic [7:0] ident_tag_reg_three;
   logic [7:0] ident_tag_reg_four;
   logic [7:0] ident_mask_reg_one;
   logic [7:0] ident_mask_reg_two;
   logic [7:0] ident_mask_reg_three;
   logic [7:0] ident_mask_reg_four;

   assign ident_tag_reg_one = regs_q[0];
   assign ident_tag_reg_two = regs_q[1];
   assign ident_tag_reg_three = regs_q[2];
   assign ident_tag_reg_four = regs_q[3];
   assign ident_mask_reg_one = regs_q[4];
   assign ident_mask_reg_two = regs_q[5];
   assign ident_mask_reg_three = regs_q[6];
   assign ident_mask_reg_four = regs_q[7];

   // ===================================================================
   // Read path, registered so data comes from a flip-flop
   always_comb
   begin
      rdata_d = rdata_q;
      if (sfr_rd)
      begin
         // Unmapped addresses answer zero so a stray read is harmless
         if (idx_ok)
         begin
            case (idx)
               3'h0: rdata_d = ident_tag_reg_one;
               3'h1: rdata_d = ident_tag_reg_two;
               3'h2: rdata_d = ident_tag_reg_three;
               3'h3: rdata_d = ident_tag_reg_four;
               3'h4: rdata_d = ident_mask_reg_one;
               3'h5: rdata_d = ident_mask_reg_two;
               3'h6: rdata_d = ident_mask_reg_three;
               3'h7: rdata_d = ident_mask_reg_four;
               default: rdata_d = `RSVD_READ;
            endcase
         end
         else
         begin
            rdata_d = `RSVD_READ;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         rdata_q <= 8'h00;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata = rdata_q;

   // ===================================================================
   // Named fields of registers one and four
   logic [7:0] ident_tag_bits;
   logic [7:0] ident_mask_bits;
   logic [7:0] std_ident_mask_bits;
   logic remote_req_tag;
   logic reserved_bit1_tag;
   logic reserved_bit0_tag;
   logic remote_req_mask;
   logic ext_format_mask;

   assign ident_tag_bits = ident_tag_reg_one; // [RL1]
   assign ident_mask_bits = ident_mask_reg_one; // [RL4]
   assign std_ident_mask_bits = ident_mask_reg_one; // [RL3]
   assign remote_req_tag = ident_tag_reg_four[`RTR_BIT]; // [RL2]
   assign reserved_bit1_tag = ident_tag_reg_four[`RB1_BIT]; // [RL2]
   assign reserved_bit0_tag = ident_tag_reg_four[`RB0_BIT]; // [RL2]
   assign remote_req_mask = ident_mask_reg_four[`RTR_BIT]; // [RL5]
   assign ext_format_mask = ident_mask_reg_four[`IDE_BIT]; // [RL5]

   // ===================================================================
   // Field unpacking; both layouts share the same addresses
   logic [28:0] tag_id;
   logic [28:0] mask_id;
   logic tag_rtr;
   logic tag_rb1;
   logic tag_rb0;
   logic mask_rtr;
   logic mask_ide;

   always_comb
   begin
      if (ext_format)
      begin
         tag_id = {ident_tag_bits, ident_tag_reg_two, ident_tag_reg_three,
            ident_tag_reg_four[7:`EXT_LOW_LSB]}; // [RL1]
         mask_id = {ident_mask_bits, ident_mask_reg_two,
            ident_mask_reg_three,
            ident_mask_reg_four[7:`EXT_LOW_LSB]}; // [RL4]
         // Reserved bit one is a real tag only in extended layout
         tag_rb1 = reserved_bit1_tag; // [RL2]
      end
      else
      begin
         // Upper identifier bits are don't-care in standard layout
         tag_id = {18'h00000, ident_tag_bits,
            ident_tag_reg_two[7:`STD_LOW_LSB]}; // [RL9]
         mask_id = {18'h00000, std_ident_mask_bits,
            ident_mask_reg_two[7:`STD_LOW_LSB]}; // [RL3]
         tag_rb1 = 1'b0;
      end
      tag_rtr = remote_req_tag; // [RL2]
      tag_rb0 = reserved_bit0_tag; // [RL2]
      mask_rtr = remote_req_mask; // [RL5]
      mask_ide = ext_format_mask; // [RL5]
   end

   // ===================================================================
   // Acceptance filter, registered result
   logic [28:0] id_miss;
   logic rtr_miss;
   logic ide_miss;
   logic accept_d;
   logic accept_q;

   // One comparator per identifier bit; cleared mask forces a match [RL5]
   genvar b;
   generate
      for (b = 0; b < `EXT_ID_BITS; b++)
      begin : g_cmp
         assign id_miss[b] = (rx_hdr.ident[b] ^ tag_id[b]) & mask_id[b];
      end
   endgenerate

   always_comb
   begin
      rtr_miss = (rx_hdr.rtr ^ tag_rtr) & mask_rtr; // [RL5]
      // Channel format stands in for the tag of the extension bit
      ide_miss = (rx_hdr.ext ^ ext_format) & mask_ide; // [RL5]
      // Reserved bits of a received frame are never compared
      accept_d = 1'b0;
      if (rx_check)
      begin
         accept_d = ~(|id_miss | rtr_miss | ide_miss); // [RL10]
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         accept_q <= 1'b0;
      end
      else
      begin
         accept_q <= accept_d;
      end
   end

   assign rx_accept = accept_q;

   // ===================================================================
   // Transmit header: built from tags and ext_format, mask has no effect [RL6]
   always_comb
   begin
      tx_hdr.ext = ext_format;
      tx_hdr.rtr = tag_rtr;
      tx_hdr.rb0 = tag_rb0;
      if (ext_format)
      begin
         tx_hdr.ident = tag_id; // [RL1]
         tx_hdr.rb1 = tag_rb1; // [RL2]
      end
      else
      begin
         // Standard frames carry only the low eleven identifier bits
         tx_hdr.ident = {18'h00000, tag_id[10:0]}; // [RL9]
         tx_hdr.rb1 = 1'b0;
      end
   end

endmodule : can_channel_id_filter_regs

// File: bench/can_filter_chk.sv
`timescale 1ns/1ns
module can_filter_chk (
   input logic mclk,
   input logic srst,
   input logic sfr_wr,
   input logic sfr_rd,
   input logic [7:0] sfr_addr,
   input logic [7:0] sfr_wdata,
   input logic [7:0] sfr_rdata,
   input logic sfr_hit,
   input logic ext_format,
   input logic rx_check,
   input can_id_filter_pkg::rx_hdr_s rx_hdr,
   input logic rx_accept,
   input can_id_filter_pkg::tx_hdr_s tx_hdr
);
   // ======================================
   // Properties
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   AST_ACC_IDLE: assert property (!rx_check |=> !rx_accept)
      else $error("accept without check");
   AST_HIT: assert property (sfr_hit == (sfr_addr[7:2] inside {6'h2f, 6'h31}))
      else $error("address decode wrong");
   AST_UNMAP: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_RDBACK: assert property (sfr_wr && sfr_hit ##1 sfr_rd
      && $stable(sfr_addr) |=> sfr_rdata == $past(sfr_wdata, 2))
      else $error("read after write differs");
   AST_T1: assert property (sfr_wr && ext_format
      && sfr_addr == 8'hbc |=> tx_hdr.ident[28:21] == $past(sfr_wdata))
      else $error("tag one field wrong");
   AST_T4: assert property (sfr_wr && ext_format
      && sfr_addr == 8'hbf |=> !ext_format || tx_hdr[7:0] == $past(sfr_wdata))
      else $error("tag four fields wrong");
   AST_STD: assert property (sfr_wr && !ext_format
      && sfr_addr == 8'hbd |=> ext_format
      || tx_hdr.ident[2:0] == $past(sfr_wdata[7:5]))
      else $error("standard tag low bits wrong");
   AST_TX_MASK: assert property (sfr_wr && sfr_addr[7:2] == 6'h31
      ##1 $stable(ext_format) |-> $stable(tx_hdr))
      else $error("mask write moved transmit header");
   cover property (rx_check ##1 rx_accept);
   cover property (rx_check ##1 !rx_accept);
   cover property (sfr_rd && !sfr_hit);
endmodule : can_filter_chk

bind can_channel_id_filter_regs can_filter_chk u_chk (.*);

// File: bench/can_node_model.sv
`timescale 1ns/1ns
module can_node_model (
   input logic mclk,
   input logic send,
   input can_id_filter_pkg::rx_hdr_s hdr,
   output logic rx_check,
   output can_id_filter_pkg::rx_hdr_s rx_hdr
);
   // ======================================
   // Header valid only with the strobe, inverted otherwise
   always_ff @(posedge mclk)
   begin
      rx_check <= send;
      rx_hdr <= send ? hdr : ~hdr;
   end
endmodule : can_node_model

// File: bench/can_channel_id_filter_regs_test.sv
`timescale 1ns/1ns
module can_channel_id_filter_regs_test;
   logic mclk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0, ext_format = 1;
   logic send = 0, rx_check, rx_accept, sfr_hit, pend = 0, sel = 0;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
   can_id_filter_pkg::rx_hdr_s hdr = 0, rx_hdr;
   can_id_filter_pkg::tx_hdr_s tx_hdr;
   logic [31:0] tg;
   logic [33:0] h;
   logic [7:0] q[$];
   int n_errors = 0, cmp_count = 0, seed = 90306, i;
   can_node_model u_node (.mclk(mclk), .send(send), .hdr(hdr),
      .rx_check(rx_check), .rx_hdr(rx_hdr));
   can_channel_id_filter_regs u_dut (.*);
   initial forever #25 mclk = ~mclk;
   // ======================================
   // Tasks
   task check(input string what, input logic [33:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task op(input logic w, r, input logic [7:0] a, d);
      sfr_wr <= w;
      sfr_rd <= r;
      sfr_addr <= a;
      sfr_wdata <= d;
      if (r) q.push_back(d);
      @(posedge mclk);
   endtask : op
   task rx(input logic [33:0] hh, input logic exp);
      hdr <= hh;
      send <= 1;
      op(0, 0, 8'h00, 8'h00);
      send <= 0;
      q.push_back({7'h0, exp});
      @(posedge mclk);
   endtask : rx
   task give_verdict;
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   // ======================================
   // Result watcher
   always @(posedge mclk)
   begin
      if (pend)
         check(sel ? "accept" : "rdata", sel ? {7'h0, rx_accept} : sfr_rdata,
            q.pop_front());
      pend = sfr_rd | rx_check;
      sel = rx_check;
   end
   initial
   begin
      repeat (2000) @(posedge mclk);
      n_errors++;
      give_verdict;
   end
   initial
   begin
      tg = {$random(seed), 3'b101};
      h = {1'b1, tg};
      repeat (3) @(posedge mclk);
      srst <= 0;
      for (i = 0; i < 4; i++)
      begin
         op(1, 0, 8'hbc + i, tg[31 - 8 * i -: 8]);
         op(0, 1, 8'hbc + i, tg[31 - 8 * i -: 8]);
      end
      op(0, 1, 8'hc0, 8'h00);
      check("tx ext", tx_hdr, h);
      // Reserved bit one of mask four kept clear
      for (i = 0; i < 4; i++)
         op(1, 0, 8'hc4 + i, i < 3 ? 8'hff : 8'hfd);
      check("tx after mask", tx_hdr, h);
      rx(h, 1);
      rx(h ^ (34'h10 << ($unsigned($random(seed)) % 29)), 0);
      rx(h ^ 34'h4, 0);
      rx(h ^ 34'h1, 1);
      rx(h ^ 34'h100000000, 0);
      op(1, 0, 8'hc4, 8'h7f);
      op(1, 0, 8'hc7, 8'hf9);
      rx(h ^ 34'h080000004, 1);
      rx(h ^ 34'h040000000, 0);
      $display("extended layout done");
      ext_format <= 0;
      op(1, 0, 8'hbc, tg[13:6]);
      op(1, 0, 8'hbd, {tg[5:3], 5'h00});
      op(1, 0, 8'hc4, 8'hff);
      op(1, 0, 8'hc5, 8'he0);
      op(1, 0, 8'hc7, 8'h05);
      h = {19'h0, tg[13:0]};
      rx(h, 1);
      check("tx std", tx_hdr, h);
      rx(h ^ 34'h10, 0);
      op(1, 0, 8'hc5, 8'hc0);
      rx(h ^ 34'h8, 1);
      repeat (3) @(posedge mclk);
      $display("standard layout done");
      give_verdict;
   end
endmodule : can_channel_id_filter_regs_test
